// ---- src/qdpc_pkg.sv ----
`default_nettype none
// Shared constants and carriers for the quad converter pin-control block
package qdpc_pkg;
  // Channel geometry
  localparam int CHANNELS   = 4;                 // Converter channels
  localparam int GROUP_SIZE = 2;                 // Channels per polarity group
  localparam int CODE_W     = 14;                // Channel code width
  localparam int CAL_W      = 8;                 // Calibration register width
  localparam int GPIO_W     = 2;                 // General-purpose pins

  // Serial frame layout
  localparam int FRAME_W    = 24;                // Bits per frame
  localparam int COUNT_W    = 5;                 // Bit counter width
  localparam int READ_BIT   = 23;                // Frame asks for readback
  localparam int ADDR_MSB   = 19;                // Address field top
  localparam int ADDR_LSB   = 16;                // Address field bottom
  localparam int ADDR_W     = 4;                 // Address field width
  localparam int CH_SEL_W   = 2;                 // Channel index inside a bank

  // Address map of the serial port
  localparam logic [ADDR_W-1:0] ADDR_GPIO = 4'h1; // Pin drive and pin levels
  localparam logic [1:0]        BANK_DATA = 2'h1; // 0x4..0x7 channel codes
  localparam logic [1:0]        BANK_ZERO = 2'h2; // 0x8..0xb zero calibration
  localparam logic [1:0]        BANK_GAIN = 2'h3; // 0xc..0xf gain calibration

  // Reset values
  localparam logic [CODE_W-1:0]  CODE_RST  = 14'h0000; // Zero scale unipolar, mid-scale bipolar
  localparam logic [CAL_W-1:0]   ZERO_RST  = 8'h00;    // Zero calibration default
  localparam logic [CAL_W-1:0]   GAIN_RST  = 8'h00;    // Gain calibration default
  localparam logic [GPIO_W-1:0]  GPIO_RST  = 2'h0;     // Pins released
  localparam logic [FRAME_W-1:0] REPLY_RST = 24'h000000;

  // Serial pins from the host
  typedef struct packed {
    logic cs_n;                                  // Chip select, active low
    logic sclk;                                  // Serial bit clock
    logic sdi;                                   // Serial data in
  } qdpc_spi_s;

  // One channel's converted output
  typedef struct packed {
    logic              unipolar;                 // Channel runs unipolar
    logic [CODE_W-1:0] level;                    // Straight-binary output level
  } qdpc_chan_s;
endpackage
`default_nettype wire

// ---- src/qdpc_shifter.sv ----
`default_nettype none
// Serial shift register framed by chip select
module qdpc_shifter
  import qdpc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire qdpc_pkg::qdpc_spi_s spi,
  input  wire logic [FRAME_W-1:0]  reply,
  output logic                     frame_valid,
  output logic [FRAME_W-1:0]       frame,
  output logic                     sdo,
  output logic                     sdo_oe
);
  logic               sclk_q;                    // Previous serial clock level
  logic               cs_q;                      // Previous chip select level
  logic [FRAME_W-1:0] shift;                     // Shift register
  logic [COUNT_W-1:0] count;                     // Bits taken this frame
  logic               next_sclk_q;
  logic               next_cs_q;
  logic [FRAME_W-1:0] next_shift;
  logic [COUNT_W-1:0] next_count;
  logic               next_frame_valid;
  logic [FRAME_W-1:0] next_frame;
  logic               next_sdo;
  logic               next_sdo_oe;
  logic               rise;                      // Qualified rising clock edge
  logic               fall;                      // Qualified falling clock edge

  // Edges count only while selected
  always_comb
  begin
    rise = ~spi.cs_n & spi.sclk & ~sclk_q;
    fall = ~spi.cs_n & ~spi.sclk & sclk_q;
    next_sclk_q      = spi.sclk;
    next_cs_q        = spi.cs_n;
    next_shift       = shift;
    next_count       = count;
    next_frame_valid = 1'b0;
    next_frame       = frame;
    next_sdo         = sdo;
    next_sdo_oe      = ~spi.cs_n;
    if (cs_q && !spi.cs_n)
    begin
      // Frame opens: preload the readback word
      next_shift = reply;
      next_count = '0;
      next_sdo   = reply[FRAME_W-1];
    end
    else if (rise)
    begin
      // Take one bit, counter saturates
      next_shift = {shift[FRAME_W-2:0], spi.sdi};
      if (count != '1)
      begin
        next_count = count + 1'b1;
      end
    end
    if (fall)
    begin
      // Present the next bit on the falling edge
      next_sdo = shift[FRAME_W-1];
    end
    if (!cs_q && spi.cs_n && count == COUNT_W'(FRAME_W))
    begin
      // Only complete frames are acted on
      next_frame_valid = 1'b1;
      next_frame       = shift;
    end
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_q      <= 1'b0;
      cs_q        <= 1'b1;
      shift       <= '0;
      count       <= '0;
      frame_valid <= 1'b0;
      frame       <= '0;
      sdo         <= 1'b0;
      sdo_oe      <= 1'b0;
    end
    else
    begin
      sclk_q      <= next_sclk_q;
      cs_q        <= next_cs_q;
      shift       <= next_shift;
      count       <= next_count;
      frame_valid <= next_frame_valid;
      frame       <= next_frame;
      sdo         <= next_sdo;
      sdo_oe      <= next_sdo_oe;
    end
  end
endmodule
`default_nettype wire

// ---- src/qdpc_top.sv ----
// How it works
// - Serial clock ignored unless chip select low
// - Serial output released while chip select high
// - Load strobe low makes latches follow inputs
// - Output level changes with its latch
// - Reset pin restores inputs and latches to code zero in both polarities
// - Reset pin restores gain and zero registers
// - General pins only pull low or release
// - Group A select high unipolar, low bipolar
// - Unipolar straight binary, bipolar two's complement
`default_nettype none
module qdpc_top
  import qdpc_pkg::*;
#(
  parameter logic GROUP_B_UNIPOLAR = 1'b0        // Mode of channels two and three
)
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire qdpc_pkg::qdpc_spi_s      spi,
  output logic                          sdo,
  output logic                          sdo_oe,
  input  wire logic                     latch_load_strobe_n,
  input  wire logic                     device_reset_n,
  input  wire logic                     group_a_polarity_select,
  input  wire logic [GPIO_W-1:0]        gpio_in,
  output logic      [GPIO_W-1:0]        gpio_out,
  output logic      [GPIO_W-1:0]        gpio_oe,
  output qdpc_pkg::qdpc_chan_s          chan [CHANNELS]
);
  import qdpc_pkg::*;

  logic               frame_valid;               // Complete frame pulse
  logic [FRAME_W-1:0] frame;                     // Captured frame
  logic [FRAME_W-1:0] reply;                     // Word shifted out next frame
  logic [FRAME_W-1:0] next_reply;
  logic [ADDR_W-1:0]  addr;                      // Frame address
  logic               is_write;                  // Frame writes a register
  logic [CODE_W-1:0]  wdata;                     // Frame payload
  logic [GPIO_W-1:0]  drive_low;                 // Pins pulled low
  logic [GPIO_W-1:0]  next_drive_low;

  // Per-channel storage
  logic [CODE_W-1:0]  in_reg   [CHANNELS];       // Input data registers
  logic [CODE_W-1:0]  latch    [CHANNELS];       // Output latches
  logic [CAL_W-1:0]   zero_cal [CHANNELS];       // Zero calibration
  logic [CAL_W-1:0]   gain_cal [CHANNELS];       // Gain calibration
  logic [CODE_W-1:0]  next_in_reg   [CHANNELS];
  logic [CODE_W-1:0]  next_latch    [CHANNELS];
  logic [CAL_W-1:0]   next_zero_cal [CHANNELS];
  logic [CAL_W-1:0]   next_gain_cal [CHANNELS];
  qdpc_chan_s         next_chan     [CHANNELS];

  // Serial framing and readback shifter
  qdpc_shifter u_shifter
  (
    .clk         (clk),
    .reset       (reset),
    .spi         (spi),
    .reply       (reply),
    .frame_valid (frame_valid),
    .frame       (frame),
    .sdo         (sdo),
    .sdo_oe      (sdo_oe)
  );

  // Frame field decode
  // The fields matter only while frame_valid pulses; the shifter holds the
  // last whole frame, so the decode never sees a half-shifted word
  always_comb
  begin
    addr     = frame[ADDR_MSB:ADDR_LSB];
    is_write = frame_valid & ~frame[READ_BIT];
    wdata    = frame[CODE_W-1:0];
  end

  // Per-channel next values
  // Priority, lowest first: serial write, load strobe, reset pin. The strobe
  // passes the post-write input value, so a write under a held-low strobe
  // reaches the output on the same edge as the input register.
  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    logic hit;                                   // Frame addresses this channel
    logic uni;                                   // Channel mode
    always_comb
    begin
      hit = is_write && addr[CH_SEL_W-1:0] == CH_SEL_W'(i);
      if (i < GROUP_SIZE)
      begin
        uni = group_a_polarity_select;
      end
      else
      begin
        uni = GROUP_B_UNIPOLAR;
      end
      next_in_reg[i]   = in_reg[i];
      next_zero_cal[i] = zero_cal[i];
      next_gain_cal[i] = gain_cal[i];
      next_latch[i]    = latch[i];
      if (hit && addr[ADDR_W-1 -: 2] == BANK_DATA)
      begin
        next_in_reg[i] = wdata;
      end
      if (hit && addr[ADDR_W-1 -: 2] == BANK_ZERO)
      begin
        next_zero_cal[i] = wdata[CAL_W-1:0];
      end
      if (hit && addr[ADDR_W-1 -: 2] == BANK_GAIN)
      begin
        next_gain_cal[i] = wdata[CAL_W-1:0];
      end
      if (!latch_load_strobe_n)
      begin
        // Transparent latch passes the input register
        next_latch[i] = next_in_reg[i];
      end
      if (!device_reset_n)
      begin
        // Reset pin wins over any write or load
        next_in_reg[i]   = CODE_RST;
        next_latch[i]    = CODE_RST;
        next_zero_cal[i] = ZERO_RST;
        next_gain_cal[i] = GAIN_RST;
      end
      // Output level derived from the new latch value in the same cycle
      next_chan[i].unipolar = uni;
      if (uni)
      begin
        next_chan[i].level = next_latch[i];
      end
      else
      begin
        // Two's complement to offset binary
        next_chan[i].level = {~next_latch[i][CODE_W-1], next_latch[i][CODE_W-2:0]};
      end
    end

    // Channel register stage
    // The level register loads on the same edge as the latch, so the output
    // never lags its latch by a separate update step
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        in_reg[i]   <= CODE_RST;
        latch[i]    <= CODE_RST;
        zero_cal[i] <= ZERO_RST;
        gain_cal[i] <= GAIN_RST;
        chan[i]     <= '0;
      end
      else
      begin
        in_reg[i]   <= next_in_reg[i];
        latch[i]    <= next_latch[i];
        zero_cal[i] <= next_zero_cal[i];
        gain_cal[i] <= next_gain_cal[i];
        chan[i]     <= next_chan[i];
      end
    end
  end

  // Pin control and readback selection
  // A read frame parks its answer in reply, which the shifter loads when
  // chip select next falls
  always_comb
  begin
    next_drive_low = drive_low;
    next_reply     = reply;
    if (is_write && addr == ADDR_GPIO)
    begin
      next_drive_low = frame[GPIO_W-1:0];
    end
    if (frame_valid && frame[READ_BIT])
    begin
      // Readback word carries the address and the selected value
      next_reply = '0;
      next_reply[ADDR_MSB:ADDR_LSB] = addr;
      unique case (addr[ADDR_W-1 -: 2])
        BANK_DATA:
        begin
          next_reply[CODE_W-1:0] = in_reg[addr[CH_SEL_W-1:0]];
        end
        BANK_ZERO:
        begin
          next_reply[CAL_W-1:0] = zero_cal[addr[CH_SEL_W-1:0]];
        end
        BANK_GAIN:
        begin
          next_reply[CAL_W-1:0] = gain_cal[addr[CH_SEL_W-1:0]];
        end
        default:
        begin
          // Low bank: pin state, other addresses read zero
          if (addr == ADDR_GPIO)
          begin
            next_reply[2*GPIO_W-1:0] = {gpio_in, drive_low};
          end
        end
      endcase
    end
  end

  // Pin control register stage
  // The pin data is tied low: an open-drain pin may only sink or let go,
  // and the enable comes from a flip-flop so the pin never glitches
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      drive_low <= GPIO_RST;
      reply     <= REPLY_RST;
      gpio_out  <= '0;
      gpio_oe   <= '0;
    end
    else
    begin
      drive_low <= next_drive_low;
      reply     <= next_reply;
      gpio_out  <= '0;
      gpio_oe   <= next_drive_low;
    end
  end
endmodule
`default_nettype wire

// ---- bench/qdpc_host.sv ----
`default_nettype none
// Host serial master, slow against the system clock
module qdpc_host
  import qdpc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sdo,
  output var  qdpc_pkg::qdpc_spi_s spi
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, bit clock low
  initial spi = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
  // One frame MSB first, reply caught while the bit clock rises
  task automatic xfer(input logic sel, input logic [FRAME_W-1:0] d,
                      output logic [FRAME_W-1:0] q);
    q = '0;
    @(posedge clk) spi.cs_n <= !sel;
    for (int i = FRAME_W - 1; i >= 0; i--)
    begin
      repeat (2) @(posedge clk);
      spi.sdi <= d[i];
      repeat (2) @(posedge clk);
      spi.sclk <= 1'b1;
      q[i] = sdo;
      repeat (2) @(posedge clk);
      spi.sclk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    spi.cs_n <= 1'b1;
    // Released line shows no stale bit
    spi.sdi <= ~spi.sdi;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/qdpc_assertions.sv ----
`default_nettype none
// Port-level checks of the pin-control block
module qdpc_chk
  import qdpc_pkg::*;
#(
  parameter logic GROUP_B_UNIPOLAR = 1'b0 // Mode of channels two and three
)
(
  input wire logic                          clk,
  input wire logic                          reset,
  input wire qdpc_pkg::qdpc_spi_s           spi,
  input wire logic                          sdo,
  input wire logic                          sdo_oe,
  input wire logic                          latch_load_strobe_n,
  input wire logic                          device_reset_n,
  input wire logic                          group_a_polarity_select,
  input wire logic [qdpc_pkg::GPIO_W-1:0]   gpio_in,
  input wire logic [qdpc_pkg::GPIO_W-1:0]   gpio_out,
  input wire logic [qdpc_pkg::GPIO_W-1:0]   gpio_oe,
  input wire qdpc_pkg::qdpc_chan_s          chan [qdpc_pkg::CHANNELS]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Serial output follows chip select one clock late
  sdo_off_a: assert property (spi.cs_n |=> !sdo_oe)
    else $error("data line driven while deselected");
  sdo_on_a: assert property (!spi.cs_n |=> sdo_oe)
    else $error("data line idle while selected");
  // Open-drain pins never drive high
  gpio_low_a: assert property (gpio_out == '0)
    else $error("general pin driven high");
  // Strobe high: levels of channels 0 and 3 hold
  latch_hold_a: assert property (latch_load_strobe_n && device_reset_n && !$past(reset)
    && $stable(group_a_polarity_select) |=> $stable(chan[0]) && $stable(chan[3]))
    else $error("level moved with strobe high");
  // Group modes; a sampled reset skips the release edge, where the
  // levels still carry their reset value
  mode_uni_a: assert property (!reset && group_a_polarity_select
    |=> chan[0].unipolar && chan[1].unipolar)
    else $error("group A not unipolar");
  mode_bip_a: assert property (!reset && !group_a_polarity_select
    |=> !chan[0].unipolar && !chan[1].unipolar)
    else $error("group A not bipolar");
  group_b_a: assert property (!reset |=> chan[2].unipolar == GROUP_B_UNIPOLAR
    && chan[3].unipolar == GROUP_B_UNIPOLAR)
    else $error("group B mode wrong");
  // Device reset gives zero volts in either coding
  rst_code_a: assert property (!device_reset_n
    |=> chan[0].level == {!chan[0].unipolar, 13'h0000}
    && chan[3].level == {!chan[3].unipolar, 13'h0000})
    else $error("reset level wrong");
  // No frame while deselected, so pins keep their drive
  idle_pins_a: assert property (spi.cs_n [*6] ##0 device_reset_n |=> $stable(gpio_oe))
    else $error("pin drive changed with no frame");
  strobe_c: cover property (!latch_load_strobe_n && !spi.cs_n);
  dev_rst_c: cover property ($fell(device_reset_n));
  gpio_c: cover property (gpio_oe != '0);
endmodule
bind qdpc_top qdpc_chk #(.GROUP_B_UNIPOLAR(GROUP_B_UNIPOLAR)) chk (
  .clk(clk), .reset(reset), .spi(spi), .sdo(sdo), .sdo_oe(sdo_oe),
  .latch_load_strobe_n(latch_load_strobe_n), .device_reset_n(device_reset_n),
  .group_a_polarity_select(group_a_polarity_select), .gpio_in(gpio_in),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .chan(chan));
`default_nettype wire

// ---- bench/testbench.sv ----
`default_nettype none
// Self-checking bench of the pin-control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import qdpc_pkg::*;
  logic               clk = 1'b0;    // System clock
  logic               reset = 1'b1;  // Synchronous reset
  logic               lds_n = 1'b1;  // Latch strobe
  logic               drst_n = 1'b1; // Device reset pin
  logic               grp_a = 1'b1;  // Group A polarity select
  qdpc_spi_s          spi;           // Host serial pins
  logic               sdo;
  logic               sdo_oe;
  logic [GPIO_W-1:0]  pin_in;        // Wire level of the general pins
  logic [GPIO_W-1:0]  pin_out;
  logic [GPIO_W-1:0]  pin_oe;
  qdpc_chan_s         chan [CHANNELS];
  logic [FRAME_W-1:0] q;             // Last reply
  int                 error_cnt = 0;
  int                 n_checks = 0;
  // Pull-ups: low only while a pin is pulled
  assign pin_in = (pin_oe & pin_out) | ~pin_oe;
  initial forever #25 clk = ~clk;
  // Released data line shows the inverse of its last bit
  qdpc_host host (.clk(clk), .sdo(sdo_oe ? sdo : ~sdo), .spi(spi));
  qdpc_top uut (.clk(clk), .reset(reset), .spi(spi), .sdo(sdo), .sdo_oe(sdo_oe),
    .latch_load_strobe_n(lds_n), .device_reset_n(drst_n),
    .group_a_polarity_select(grp_a), .gpio_in(pin_in), .gpio_out(pin_out),
    .gpio_oe(pin_oe), .chan(chan));
  // Compare and count
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register write frame
  task automatic wr(input logic [3:0] a, input logic [13:0] v);
    host.xfer(1'b1, {4'h0, a, 2'h0, v}, q);
  endtask
  // Read: reply comes in the following frame
  task automatic rd(input logic [3:0] a);
    host.xfer(1'b1, {4'h8, a, 16'h0000}, q);
    host.xfer(1'b1, 24'h000000, q);
  endtask
  // Unipolar code held, then passed by the strobe
  task automatic t_latch;
    wr(4'h4, 14'h3a5c);
    check(chan[0], {1'b1, 14'h0000});
    lds_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(chan[0], {1'b1, 14'h3a5c});
    lds_n <= 1'b1;
  endtask
  // Bipolar two's complement, negative code
  task automatic t_bipolar;
    grp_a <= 1'b0;
    wr(4'h5, 14'h3fff);
    lds_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(chan[1], {1'b0, 14'h1fff});
    check(chan[0], {1'b0, 14'h1a5c});
    rd(4'h5);
    check({q[19:16], q[13:0]}, {4'h5, 14'h3fff});
  endtask
  // Frame with chip select high is ignored
  task automatic t_nosel;
    host.xfer(1'b0, {8'h05, 2'h0, 14'h0123}, q);
    check(chan[1], {1'b0, 14'h1fff});
  endtask
  // Calibration and codes restored by the reset pin
  task automatic t_cal;
    wr(4'hc, 14'h0055);
    wr(4'h8, 14'h0033);
    rd(4'hc);
    check({q[19:16], q[7:0]}, {4'hc, 8'h55});
    drst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(chan[1], {1'b0, 14'h2000});
    check(chan[2], {1'b0, 14'h2000});
    drst_n <= 1'b1;
    rd(4'hc);
    check({q[19:16], q[7:0]}, {4'hc, 8'h00});
    rd(4'h8);
    check({q[19:16], q[7:0]}, {4'h8, 8'h00});
  endtask
  // Open-drain pin pulled low and read back
  task automatic t_gpio;
    wr(4'h1, 14'h0001);
    check({pin_oe, pin_out}, {2'h1, 2'h0});
    rd(4'h1);
    check({q[19:16], q[3:0]}, {4'h1, 4'h9});
  endtask
  // Verdict and end of run
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_latch();
    t_bipolar();
    t_nosel();
    t_cal();
    t_gpio();
    test_done();
  end
endmodule
`default_nettype wire
